/* hw/otgc_pkg.sv */
// Shared constants for the OTG function control register and its link-side controller.
// Assumes one 125 MHz clock feeds both ends and software reaches the controller over APB.
package otgc_pkg;

  // ==========================================================================
  // Register port addresses
  localparam logic [5:0] OTGC_ADDR_WRITE = 6'h0a;
  localparam logic [5:0] OTGC_ADDR_SET   = 6'h0b;
  localparam logic [5:0] OTGC_ADDR_CLEAR = 6'h0c;

  // ==========================================================================
  // Field positions and reset value of otg_function_control
  localparam int OTGC_BIT_EXT_VALID_SEL = 7;
  localparam int OTGC_BIT_EXT_SUPPLY    = 6;
  localparam int OTGC_BIT_DRIVE         = 5;
  localparam int OTGC_BIT_CHARGE        = 4;
  localparam int OTGC_BIT_DISCHARGE     = 3;
  localparam int OTGC_BIT_MINUS_PD      = 2;
  localparam int OTGC_BIT_PLUS_PD       = 1;
  localparam int OTGC_BIT_ID_SAMPLER    = 0;
  localparam logic [7:0] OTGC_RESET     = 8'h06;
  localparam logic [7:0] OTGC_ZERO      = 8'h00;

  // ==========================================================================
  // Access kinds decoded from a port address
  typedef enum logic [1:0] {OTGC_ACC_NONE, OTGC_ACC_WRITE, OTGC_ACC_SET, OTGC_ACC_CLEAR} otgc_acc_t;

  function automatic otgc_acc_t otgc_decode(input logic [5:0] addr);
    case (addr)
      OTGC_ADDR_WRITE: otgc_decode = OTGC_ACC_WRITE;
      OTGC_ADDR_SET:   otgc_decode = OTGC_ACC_SET;
      OTGC_ADDR_CLEAR: otgc_decode = OTGC_ACC_CLEAR;
      default:         otgc_decode = OTGC_ACC_NONE;
    endcase
  endfunction

  // ==========================================================================
  // Controller APB map and command fields
  localparam logic [7:0] OTGC_APB_CMD    = 8'h00;
  localparam logic [7:0] OTGC_APB_STATUS = 8'h04;
  localparam logic [7:0] OTGC_APB_AUTO   = 8'h08;
  localparam int OTGC_CMD_ADDR_LSB = 8;
  localparam int OTGC_CMD_WE_BIT   = 16;
  localparam int OTGC_ST_RDATA_LSB = 8;

  // ==========================================================================
  // Timing
  localparam int OTGC_CLOCK_MHZ = 125;
  localparam int OTGC_SE0_MS    = 2;
  localparam int OTGC_SE0_CYCLES = OTGC_SE0_MS * 1000 * OTGC_CLOCK_MHZ;

endpackage

/* hw/otgc_if.sv */
// Register port joining the link controller to the OTG function control register.
// Assumes both ends share one clock; the bench supplies it outside the interface.
`timescale 1ns/1ns
interface otgc_if;
  logic       req;      // Link request, held until ack
  logic       we;       // 1 write, 0 read
  logic [5:0] addr;
  logic [7:0] wdata;
  logic       ack;      // One-cycle answer
  logic [7:0] rdata;
  logic       session_end_indication; // Session end level, stands in for the RXCMD report

  // ==========================================================================
  // Device end
  modport device (input req, we, addr, wdata, output ack, rdata, session_end_indication);
  // ==========================================================================
  // Link end
  modport link (output req, we, addr, wdata, input ack, rdata, session_end_indication);
endinterface

/* hw/otgc_device.sv */
// OTG function control register of the transceiver, with its VBUS and line controls.
// Assumes the link holds a request until ack; analog pins are asynchronous and synchronised here.
// Set and clear ports act on the register already in force, so the link never needs
// a read-modify-write to change one bit.
// Every output but the tied-low switch pin comes from a flip-flop, so no pin glitches while a write lands.
`timescale 1ns/1ns
module otgc_device (
  // Clock and reset
  input  wire logic i_clock,
  input  wire logic i_rst,
  // Register port towards the link
  otgc_if.device    bus,
  // Analog indications, asynchronous
  input  wire logic i_vbus_comp_valid,
  input  wire logic i_fault,
  input  wire logic i_session_end_indication_comp,
  input  wire logic i_id_level,
  // VBUS controls
  output logic      o_vbus_valid,
  output logic      o_power_switch_out_n,
  output logic      o_power_switch_oe,
  output logic      o_internal_pump_enable,
  output logic      o_vbus_drive_enable,
  output logic      o_vbus_charge_enable,
  output logic      o_vbus_discharge_enable,
  // Line controls
  output logic      o_minus_line_pulldown_enable,
  output logic      o_plus_line_pulldown_enable,
  output logic      o_id_line_sampler_enable,
  output logic      o_id_sampled,
  // Register image
  output logic [7:0] o_otg_function_control
);

  // ==========================================================================
  // State
  // Whole state in one record; pin stages live here so reset clears them too
  typedef struct packed {
    logic [7:0] otg;        // otg_function_control
    logic       ack;
    logic [7:0] rdata;
    logic [1:0] sync_comp;  // [0] first stage, [1] second
    logic [1:0] sync_fault;
    logic [1:0] sync_send;
    logic [1:0] sync_id;
    logic       vbus_valid;
    logic       pump_on;
    logic       id_sampled;
  } otgc_dev_state_t;

  otgc_dev_state_t state;
  otgc_dev_state_t next_state;
  // Port kind decoded from the address now on the bus
  otgc_pkg::otgc_acc_t acc;

  // ==========================================================================
  // Byte update for the three write ports
  // One path for write, set and clear, so all three see the same old value
  function automatic logic [7:0] otgc_apply(input otgc_pkg::otgc_acc_t kind,
                                            input logic [7:0]          old_value,
                                            input logic [7:0]          data);
    case (kind)
      otgc_pkg::OTGC_ACC_WRITE: otgc_apply = data;
      otgc_pkg::OTGC_ACC_SET:   otgc_apply = old_value | data;
      otgc_pkg::OTGC_ACC_CLEAR: otgc_apply = old_value & ~data;
      // Unmapped write ignored
      default:                  otgc_apply = old_value;
    endcase
  endfunction

  // ==========================================================================
  // Next state
  always_comb
  begin
    next_state = state;
    acc        = otgc_pkg::otgc_decode(bus.addr);
    // A pin may change at any instant, so its first stage may be metastable
    // Two stages per pin; only the second stage is read below
    next_state.sync_comp  = {state.sync_comp[0], i_vbus_comp_valid};
    next_state.sync_fault = {state.sync_fault[0], i_fault};
    next_state.sync_send  = {state.sync_send[0], i_session_end_indication_comp};
    next_state.sync_id    = {state.sync_id[0], i_id_level};
    // Ack pulses once per held request, so a request held over two edges acts once
    // and the link sees exactly one answer per transfer
    next_state.ack   = bus.req & ~state.ack;
    next_state.rdata = state.rdata;
    // Transfer taken: a write lands at this edge, read data stands from the ack cycle
    if (bus.req && !state.ack)
    begin
      if (bus.we)
      begin
        next_state.otg = otgc_apply(acc, state.otg, bus.wdata);
      end
      else
      begin
        // three read aliases
        // Any of the three aliases returns the same byte
        if (acc != otgc_pkg::OTGC_ACC_NONE)
        begin
          next_state.rdata = state.otg;
        end
        else
        begin
          next_state.rdata = otgc_pkg::OTGC_ZERO; // Unmapped reads return zero
        end
      end
    end
    // VBUS valid source select, using the register value already in force
    // Both sources pass the same two stages, so a switch adds no extra delay
    if (state.otg[otgc_pkg::OTGC_BIT_EXT_VALID_SEL])
    begin
      next_state.vbus_valid = state.sync_fault[1];
    end
    else
    begin
      next_state.vbus_valid = state.sync_comp[1];
    end
    // Drive bit alone leaves the pump off once the external supply is chosen
    // pump only while internal supply chosen
    next_state.pump_on = next_state.otg[otgc_pkg::OTGC_BIT_DRIVE]
                       & ~next_state.otg[otgc_pkg::OTGC_BIT_EXT_SUPPLY];
    // sample ID only while enabled; hold last sample to save power
    if (state.otg[otgc_pkg::OTGC_BIT_ID_SAMPLER])
    begin
      next_state.id_sampled = state.sync_id[1];
    end
  end

  // ==========================================================================
  // Register
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      state            <= '0;
      // Default image: both line pull-downs on, everything else off
      state.otg        <= otgc_pkg::OTGC_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Port answers
  // Session end goes over synchronised; it stands in for the status report
  assign bus.ack      = state.ack;
  assign bus.rdata    = state.rdata;
  assign bus.session_end_indication = state.sync_send[1];

  // ==========================================================================
  // VBUS valid indication
  assign o_vbus_valid = state.vbus_valid;

  // ==========================================================================
  // Power switch
  // Open drain: the pin is only ever pulled low, a board pull-up keeps it high
  // switch output driven low while the external supply bit is set
  assign o_power_switch_out_n   = 1'b0;
  assign o_power_switch_oe      = state.otg[otgc_pkg::OTGC_BIT_EXT_SUPPLY];
  assign o_internal_pump_enable = state.pump_on;

  // ==========================================================================
  // VBUS drive, charge and discharge
  // Enables are plain register bits; the analog side limits the currents
  // drive 5 V while set
  assign o_vbus_drive_enable     = state.otg[otgc_pkg::OTGC_BIT_DRIVE];
  assign o_vbus_charge_enable    = state.otg[otgc_pkg::OTGC_BIT_CHARGE];
  assign o_vbus_discharge_enable = state.otg[otgc_pkg::OTGC_BIT_DISCHARGE];

  // ==========================================================================
  // Line pull-downs
  // Both reset on, so an idle bus rests at SE0
  // pull-downs follow bits
  assign o_minus_line_pulldown_enable = state.otg[otgc_pkg::OTGC_BIT_MINUS_PD];
  assign o_plus_line_pulldown_enable  = state.otg[otgc_pkg::OTGC_BIT_PLUS_PD];

  // ==========================================================================
  // ID line
  // ID sampler enable follows bit
  assign o_id_line_sampler_enable = state.otg[otgc_pkg::OTGC_BIT_ID_SAMPLER];
  assign o_id_sampled             = state.id_sampled;

  // ==========================================================================
  // Register image
  // Mirrors the register for logic that watches the transceiver directly
  assign o_otg_function_control = state.otg;

endmodule // otgc_device

/* hw/otgc_link.sv */
// Link-side controller: takes register commands over APB and runs them on the register port.
// Assumes the device answers each held request with a one-cycle ack; se0 pin is asynchronous.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ns
module otgc_link #(
  parameter int SE0_CYCLES = otgc_pkg::OTGC_SE0_CYCLES
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // APB slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic             o_pready,
  output logic             o_pslverr,
  output logic [31:0]      o_prdata,
  // Line state
  input  wire logic        i_line_se0,
  // Register port towards the device
  otgc_if.link             bus
);

  typedef enum {OTGC_IDLE, OTGC_BUSY} otgc_link_st_t;

  // ==========================================================================
  // State
  typedef struct packed {
    otgc_link_st_t fsm;
    logic          we;
    logic [5:0]    addr;
    logic [7:0]    wdata;
    logic [7:0]    rdata;
    logic          refused;
    logic          auto_en;
    logic          armed;     // Discharge running under auto end
    logic          send_prev;
    logic          end_pending;
    logic [1:0]    sync_se0;
    logic [31:0]   se0_count;
    logic [31:0]   prdata;
  } otgc_link_state_t;

  otgc_link_state_t state;
  otgc_link_state_t next_state;
  logic             apb_wr;
  logic             apb_rd;
  logic             se0_ok;
  logic             cmd_charge;
  logic             cmd_discharge;
  otgc_pkg::otgc_acc_t cmd_acc;

  // ==========================================================================
  // Next state
  always_comb
  begin
    next_state    = state;
    apb_wr        = i_psel & i_penable & i_pwrite;
    apb_rd        = i_psel & i_penable & ~i_pwrite;
    cmd_acc       = otgc_pkg::otgc_decode(i_pwdata[otgc_pkg::OTGC_CMD_ADDR_LSB +: 6]);
    se0_ok        = state.se0_count >= SE0_CYCLES;
    cmd_charge    = i_pwdata[otgc_pkg::OTGC_CMD_WE_BIT] & i_pwdata[otgc_pkg::OTGC_BIT_CHARGE]
                  & ((cmd_acc == otgc_pkg::OTGC_ACC_WRITE) | (cmd_acc == otgc_pkg::OTGC_ACC_SET));
    cmd_discharge = i_pwdata[otgc_pkg::OTGC_CMD_WE_BIT] & i_pwdata[otgc_pkg::OTGC_BIT_DISCHARGE]
                  & ((cmd_acc == otgc_pkg::OTGC_ACC_WRITE) | (cmd_acc == otgc_pkg::OTGC_ACC_SET));
    next_state.sync_se0  = {state.sync_se0[0], i_line_se0};
    next_state.send_prev = bus.session_end_indication;
    if (!state.sync_se0[1])
    begin
      next_state.se0_count = '0;
    end
    else if (!se0_ok)
    begin
      next_state.se0_count = state.se0_count + 32'h1;
    end
    // remember a session end rise while discharge runs
    if (state.armed && bus.session_end_indication && !state.send_prev)
    begin
      next_state.end_pending = 1'b1;
    end
    case (state.fsm)
      OTGC_IDLE:
      begin
        if (apb_wr && i_paddr == otgc_pkg::OTGC_APB_CMD)
        begin
          // refuse charge unless discharged and SE0 long enough
          if (cmd_charge && !(se0_ok && bus.session_end_indication))
          begin
            next_state.refused = 1'b1;
          end
          else
          begin
            next_state.refused = 1'b0;
            next_state.fsm     = OTGC_BUSY;
            next_state.we      = i_pwdata[otgc_pkg::OTGC_CMD_WE_BIT];
            next_state.addr    = i_pwdata[otgc_pkg::OTGC_CMD_ADDR_LSB +: 6];
            next_state.wdata   = i_pwdata[7:0];
            // drive bit passed as given, never forced
            if (cmd_discharge)
            begin
              next_state.armed = state.auto_en;
            end
          end
        end
        else if (state.end_pending)
        begin
          // clear discharge bit via clear address
          next_state.end_pending = 1'b0;
          next_state.armed       = 1'b0;
          next_state.fsm         = OTGC_BUSY;
          next_state.we          = 1'b1;
          next_state.addr        = otgc_pkg::OTGC_ADDR_CLEAR;
          next_state.wdata       = 8'h01 << otgc_pkg::OTGC_BIT_DISCHARGE;
        end
      end
      OTGC_BUSY:
      begin
        if (apb_wr && i_paddr == otgc_pkg::OTGC_APB_CMD)
        begin
          next_state.refused = 1'b1; // Busy: command dropped
        end
        if (bus.ack)
        begin
          next_state.fsm = OTGC_IDLE;
          if (!state.we)
          begin
            next_state.rdata = bus.rdata;
          end
        end
      end
      default: next_state.fsm = OTGC_IDLE;
    endcase
    if (apb_wr && i_paddr == otgc_pkg::OTGC_APB_AUTO)
    begin
      next_state.auto_en = i_pwdata[0];
    end
    // Read data registered in the setup cycle, so it stands through the access phase
    next_state.prdata = '0;
    if (i_psel && !i_pwrite && i_paddr == otgc_pkg::OTGC_APB_STATUS)
    begin
      next_state.prdata = {16'h0, next_state.rdata, 3'h0, state.armed, se0_ok,
                           bus.session_end_indication, next_state.refused, next_state.fsm == OTGC_BUSY};
    end
    else if (i_psel && !i_pwrite && i_paddr == otgc_pkg::OTGC_APB_AUTO)
    begin
      next_state.prdata = {31'h0, state.auto_en};
    end
    if (apb_rd)
    begin
      next_state.prdata = state.prdata; // Hold during access
    end
  end

  // ==========================================================================
  // Register
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
    begin
      state     <= '0;
      state.fsm <= OTGC_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Outputs
  assign o_pready  = 1'b1;
  assign o_pslverr = 1'b0;
  assign o_prdata  = state.prdata;
  // requests carry the command's port address unchecked, mapped or not
  assign bus.req   = state.fsm == OTGC_BUSY;
  assign bus.we    = state.we;
  assign bus.addr  = state.addr;
  assign bus.wdata = state.wdata;

endmodule // otgc_link

/* sim/otgc_port_sva.sv */
// Checker for the register port between the link controller and the OTG register.
// Assumes one clock and an asynchronous active-high reset shared by both ends.
`timescale 1ns/1ns
module otgc_port_sva (
  // Clock and reset
  input wire logic       i_clock,
  input wire logic       i_rst,
  // Port signals
  input wire logic       req,
  input wire logic       we,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       ack,
  input wire logic [7:0] rdata,
  input wire logic       session_end_indication
);
  logic [7:0] img;
  logic       take;
  logic       mapped;

  // Request accepted at this edge; mapped covers all three ports
  assign take   = req && !ack;
  assign mapped = addr inside {otgc_pkg::OTGC_ADDR_WRITE, otgc_pkg::OTGC_ADDR_SET, otgc_pkg::OTGC_ADDR_CLEAR};

  // Shadow image, so reads are judged against every write seen so far
  always_ff @(posedge i_clock or posedge i_rst)
  begin
    if (i_rst)
      img <= otgc_pkg::OTGC_RESET;
    else if (take && we && addr == otgc_pkg::OTGC_ADDR_WRITE)
      img <= wdata;
    else if (take && we && addr == otgc_pkg::OTGC_ADDR_SET)
      img <= img | wdata;
    else if (take && we && addr == otgc_pkg::OTGC_ADDR_CLEAR)
      img <= img & ~wdata;
  end

  // ==========================================================================
  // Port assertions
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  ack_follows_req_a: assert property (take |=> ack)
    else $error("request not answered next cycle");
  ack_one_pulse_a: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  ack_has_cause_a: assert property ($rose(ack) |-> $past(req))
    else $error("ack without request");
  req_held_a: assert property (take |=> req && $stable({we, addr, wdata}))
    else $error("request changed before ack");
  req_release_a: assert property (ack |=> !req)
    else $error("request not dropped after ack");
  read_back_a: assert property (take && !we && mapped |=> rdata == $past(img))
    else $error("read data differs from register");
  unmapped_read_a: assert property (take && !we && !mapped |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  charge_guard_a: assert property (take && we && (addr == otgc_pkg::OTGC_ADDR_WRITE ||
    addr == otgc_pkg::OTGC_ADDR_SET) && wdata[otgc_pkg::OTGC_BIT_CHARGE] |-> session_end_indication)
    else $error("charge requested before discharge");

  // Main scenarios reached
  cover property (take && we && addr == otgc_pkg::OTGC_ADDR_SET);
  cover property (take && we && addr == otgc_pkg::OTGC_ADDR_CLEAR);
  cover property ($rose(session_end_indication));
endmodule // otgc_port_sva

/* sim/otg_vbus_control_register_test.sv */
// Bench joining link and device; software drives the link over APB.
// Assumes SE0 qualification shortened to 20 cycles.
`timescale 1ns/1ns
module otg_vbus_control_register_test;
  logic i_clock, i_rst, psel, penable, pwrite, pready, pslverr, se0;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, st;
  logic comp, fault, sess, idl, vvalid, power_switch_out_n, psw_oe, pump, drv, chg, dis, mpd, ppd, ids, idv;
  logic [7:0] image;
  int errors, checked, cycles;
  otgc_if bus_if ();
  otgc_device u_otgc_device (.i_clock(i_clock), .i_rst(i_rst), .bus(bus_if.device),
    .i_vbus_comp_valid(comp), .i_fault(fault), .i_session_end_indication_comp(sess), .i_id_level(idl),
    .o_vbus_valid(vvalid), .o_power_switch_out_n(power_switch_out_n), .o_power_switch_oe(psw_oe),
    .o_internal_pump_enable(pump), .o_vbus_drive_enable(drv), .o_vbus_charge_enable(chg),
    .o_vbus_discharge_enable(dis), .o_minus_line_pulldown_enable(mpd),
    .o_plus_line_pulldown_enable(ppd), .o_id_line_sampler_enable(ids), .o_id_sampled(idv),
    .o_otg_function_control(image));
  otgc_link #(.SE0_CYCLES(20)) u_otgc_link (.i_clock(i_clock), .i_rst(i_rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_prdata(prdata), .i_line_se0(se0), .bus(bus_if.link));
  otgc_port_sva chk (.i_clock(i_clock), .i_rst(i_rst), .req(bus_if.req), .we(bus_if.we),
    .addr(bus_if.addr), .wdata(bus_if.wdata), .ack(bus_if.ack), .rdata(bus_if.rdata),
    .session_end_indication(bus_if.session_end_indication));

  // ==========================================================================
  // Clock and hang guard; 5000 cycles is well beyond the whole sequence
  always #4 i_clock = ~i_clock;
  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      $display("unexpected %0t timeout", $time);
      wrap_up();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clock);
    penable <= 1'b1;
    @(posedge i_clock);
    while (pready !== 1'b1) @(posedge i_clock);
    st = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register port command, then poll busy; st holds the final status
  task automatic cmd(input logic w, input logic [5:0] a, input logic [7:0] d);
    int n;
    apb(1'b1, otgc_pkg::OTGC_APB_CMD, {15'h0000, w, 2'b00, a, d});
    n = 0;
    do
    begin
      apb(1'b0, otgc_pkg::OTGC_APB_STATUS, 32'h0);
      n++;
    end
    while (st[0] !== 1'b0 && n < 20);
    check(st[0], 1'b0, "command finished");
  endtask

  task automatic t_reset();
    check(image, 8'h06, "reset image");
    check({mpd, ppd, ids, drv, chg, dis, psw_oe}, 7'b1100000, "reset controls");
    $display("test reset done");
  endtask

  task automatic t_ports();
    cmd(1'b1, 6'h0a, 8'he9);
    check(image, 8'he9, "direct write");
    check({drv, pump, dis, mpd, ppd, ids}, 6'b101001, "controls follow");
    check(psw_oe ? power_switch_out_n : 1'b1, 1'b0, "switch low");
    cmd(1'b1, 6'h0b, 8'h02);
    check(image, 8'heb, "set ORs");
    cmd(1'b1, 6'h0c, 8'h61);
    check(image, 8'h8a, "clear drops");
    check(psw_oe ? power_switch_out_n : 1'b1, 1'b1, "switch released");
    cmd(1'b1, 6'h0a, 8'haa);
    check({drv, pump, psw_oe}, 3'b110, "internal pump");
    cmd(1'b1, 6'h0a, 8'hca);
    check({drv, pump, psw_oe, power_switch_out_n}, 4'b0010, "external, drive clear");
    cmd(1'b1, 6'h0a, 8'h8a);
    check(pslverr, 1'b0, "slave error");
    for (int a = 10; a <= 13; a++)
    begin
      cmd(1'b0, a[5:0], 8'h00);
      check(st[15:8], (a == 13) ? 8'h00 : 8'h8a, "read port");
    end
    $display("test ports done");
  endtask

  task automatic t_source();
    comp <= 1'b1;
    fault <= 1'b0;
    cmd(1'b1, 6'h0c, 8'h80);
    repeat (5) @(posedge i_clock);
    check(vvalid, 1'b1, "comparator source");
    cmd(1'b1, 6'h0b, 8'h80);
    repeat (5) @(posedge i_clock);
    check(vvalid, 1'b0, "fault source");
    fault <= 1'b1;
    comp <= 1'b0;
    repeat (5) @(posedge i_clock);
    check(vvalid, 1'b1, "fault followed");
    idl <= 1'b1;
    repeat (5) @(posedge i_clock);
    check(idv, 1'b0, "id not sampled");
    cmd(1'b1, 6'h0b, 8'h01);
    repeat (5) @(posedge i_clock);
    check(idv, 1'b1, "id sampled");
    $display("test source done");
  endtask

  task automatic t_discharge();
    apb(1'b1, otgc_pkg::OTGC_APB_AUTO, 32'h1);
    apb(1'b0, otgc_pkg::OTGC_APB_AUTO, 32'h0);
    check(st, 32'h1, "auto read back");
    cmd(1'b1, 6'h0c, 8'h08);
    check(dis, 1'b0, "not discharging");
    cmd(1'b1, 6'h0b, 8'h08);
    check({st[4], dis}, 2'b11, "discharging, armed");
    sess <= 1'b1;
    repeat (20) @(posedge i_clock);
    check({dis, image[3]}, 2'b00, "auto end");
    $display("test discharge done");
  endtask

  task automatic t_charge();
    cmd(1'b1, 6'h0b, 8'h10);
    check({st[1], chg}, 2'b10, "charge refused");
    se0 <= 1'b1;
    repeat (30) @(posedge i_clock);
    cmd(1'b1, 6'h0b, 8'h10);
    check({st[1], chg, image[4]}, 3'b011, "charge accepted");
    $display("test charge done");
  endtask

  task automatic wrap_up();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    i_clock = 0;
    i_rst = 1;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    se0 = 0;
    comp = 0;
    fault = 0;
    sess = 0;
    idl = 0;
    errors = 0;
    checked = 0;
    cycles = 0;
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    t_reset();
    t_ports();
    t_source();
    t_discharge();
    t_charge();
    wrap_up();
  end
endmodule // otg_vbus_control_register_test
